// ==== testbench/cfr_ctrl_asserts.sv ====
// Port-level assertions for the cold-fault response controller
`timescale 1ns/1ps
`default_nettype none
module cfr_ctrl_asserts
(
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Command port
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_cmd_wdata,
  input wire [15:0] o_cmd_rdata,
  input wire o_cmd_ack,
  // Controls and outputs
  input wire i_status_clr,
  input wire i_clear_faults,
  input wire i_op_on,
  input wire i_ctrl_pin,
  input wire i_other_fault,
  input wire o_out_en,
  input wire o_fault_status,
  input wire [15:0] o_ovlim
);
  // ==========
  // Shadow of the action byte
  logic [7:0] act_r;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      act_r <= 8'h00;
    else if (i_cmd_wr && i_cmd_code == 8'h54)
      act_r <= i_cmd_wdata[7:0];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ack_follows_req: assert property ((i_cmd_wr || i_cmd_rd) |=> o_cmd_ack)
    else $error("Ack missing");
  a_ack_only_after: assert property (!(i_cmd_wr || i_cmd_rd) |=> !o_cmd_ack)
    else $error("Stray ack");
  a_rdata_holds: assert property (!i_cmd_rd |=> $stable(o_cmd_rdata))
    else $error("Read data moved");
  a_ovlim_loads: assert property (i_cmd_wr && i_cmd_code == 8'h55 |=>
    o_ovlim == $past(i_cmd_wdata)) else $error("Limit not loaded");
  a_ovlim_holds: assert property (!(i_cmd_wr && i_cmd_code == 8'h55) |=>
    $stable(o_ovlim)) else $error("Limit moved");
  a_ignore_quiet: assert property (act_r[7:6] == 2'b00 && !i_cmd_wr && !o_fault_status
    |=> !o_fault_status) else $error("Status set while ignoring");
  a_ignore_runs: assert property (act_r[7:6] == 2'b00 && !i_cmd_wr && o_out_en && i_ctrl_pin
    && i_op_on && !i_other_fault |=> o_out_en) else $error("Output dropped while ignoring");
  a_latch_holds: assert property (i_ctrl_pin[*8] ##0 (!o_out_en && i_op_on
    && (act_r[7:6] == 2'b11 || act_r[7:3] == 5'b10000) && !i_status_clr && !i_clear_faults
    && !i_cmd_wr) |=> !o_out_en) else $error("Latched output restarted");
endmodule
bind cfr_ctrl cfr_ctrl_asserts i_cfr_ctrl_asserts (.*);
`default_nettype wire

// ==== testbench/cfr_host.sv ====
// Host model driving the command port
`timescale 1ns/1ps
`default_nettype none
module cfr_host
(
  // Clock
  input wire logic i_clk,
  // Command port
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata,
  input wire logic [15:0] i_rdata,
  input wire logic i_ack
);
  // ==========
  // One command pulse, data taken while ack stands
  initial {o_wr, o_rd, o_code, o_wdata} = '0;
  task acc(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    begin
      @(posedge i_clk);
      o_wr <= w;
      o_rd <= !w;
      o_code <= c;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_rd <= 1'b0;
      o_wdata <= ~d;
      #1 q = i_ack ? i_rdata : 16'hxxxx;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_cfr_ctrl.sv ====
// Self-checking bench for the cold-fault response controller
`timescale 1ns/1ps
`default_nettype none
module tb_cfr_ctrl;
  // ==========
  // Signals
  logic i_clk = 0, i_rstn = 0, i_cmd_wr, i_cmd_rd, i_status_clr = 0, i_clear_faults = 0;
  logic i_op_on = 1, i_ctrl_pin = 1, i_other_fault = 0, o_cmd_ack, o_out_en, o_fault_status, prev;
  logic [7:0] i_cmd_code;
  logic [15:0] i_cmd_wdata, o_cmd_rdata, o_ovlim, q, i_unit_cycles = 16'h0002;
  logic signed [15:0] i_temp = 16'sd100;
  logic [7:0] cd [4] = '{8'h53, 8'h54, 8'h55, 8'h99};
  logic [15:0] rv [4] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000};
  logic [15:0] wv [4] = '{16'h0010, 16'h12a5, 16'h1234, 16'h5555};
  logic [15:0] bv [4] = '{16'h0010, 16'h00a5, 16'h1234, 16'h0000};
  int err_total = 0, tests_run = 0, rises, first, off, n, c, r, d;
  cfr_ctrl i_cfr_ctrl (.*);
  cfr_host i_cfr_host (.i_clk(i_clk), .o_wr(i_cmd_wr), .o_rd(i_cmd_rd), .o_code(i_cmd_code),
    .o_wdata(i_cmd_wdata), .i_rdata(o_cmd_rdata), .i_ack(o_cmd_ack));
  always #12.5 i_clk = ~i_clk;
  // ==========
  // Compare, verdict, fault run and clear helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        err_total++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task watch(input logic [7:0] act, input int cyc);
    begin
      i_cfr_host.acc(1'b1, 8'h54, {8'h00, act}, q);
      @(posedge i_clk) i_temp <= -16'sd5;
      {rises, off, first, prev} = 1;
      for (n = 1; n <= cyc; n++)
      begin
        @(posedge i_clk) #1;
        if (!o_out_en && off == 0) off = n;
        if (o_out_en && !prev && first == 0) first = n;
        if (o_out_en && !prev) rises++;
        prev = o_out_en;
      end
    end
  endtask
  task clr(input int k);
    begin
      @(posedge i_clk) i_temp <= 16'sd100;
      i_clear_faults <= (k == 0);
      i_status_clr <= (k == 1);
      i_ctrl_pin <= (k != 2);
      repeat (6) @(posedge i_clk);
      {i_clear_faults, i_status_clr, i_ctrl_pin} <= 3'b001;
      repeat (10) @(posedge i_clk) #1;
      chk(o_out_en, 1'b1);
      chk(o_fault_status, 1'b0);
    end
  endtask
  // ==========
  // Test sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_clk);
    for (n = 0; n < 4; n++)
    begin
      i_cfr_host.acc(1'b0, cd[n], 16'h0000, q);
      chk(q, rv[n]);
      i_cfr_host.acc(1'b1, cd[n], wv[n], q);
      i_cfr_host.acc(1'b0, cd[n], 16'h0000, q);
      chk(q, bv[n]);
    end
    chk(o_ovlim, 16'h1234);
    watch(8'h00, 30);
    chk(16'(off + rises), 16'h0000);
    clr(0);
    $display("Done: registers and ignore");
    for (c = 0; c < 3; c++)
      for (r = 0; r < 4; r++)
      begin
        d = 2 << c;
        watch({2'b10, r[2:0], c[2:0]}, 90);
        chk(16'(rises), 16'(r));
        chk(o_out_en, 1'b0);
        if (r > 0) chk(16'(first - off >= d - 1 && first - off <= d + 2), 1);
        clr(0);
      end
    watch(8'h4b, 40);
    chk(16'(off >= 15 && off <= 20), 16'h0001);
    clr(0);
    watch(8'hc7, 40);
    chk(o_out_en, 1'b0);
    chk(o_fault_status, 1'b1);
    clr(1);
    watch(8'hc7, 20);
    clr(2);
    watch(8'hb8, 60);
    chk(16'(rises > 6), 16'h0001);
    @(posedge i_clk) i_other_fault <= 1'b1;
    watch(8'hb8, 30);
    chk(16'(rises), 16'h0000);
    chk(o_out_en, 1'b0);
    i_other_fault <= 1'b0;
    clr(0);
    $display("Done: responses");
    give_verdict;
  end
  initial
  begin
    #500000;
    err_total++;
    give_verdict;
  end
endmodule
`default_nettype wire

// ==== verilog/cfr_ctrl.v ====
// Cold-fault response controller with its command registers
`timescale 1ns/1ps
`default_nettype none
`include "cfr_map.vh"
module cfr_ctrl
(
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Command port from the transport layer
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_cmd_wdata,
  output reg [15:0] o_cmd_rdata,
  output reg o_cmd_ack,
  // Measurement and time unit (unit cycles from the 0xD2 register)
  input wire signed [15:0] i_temp,
  input wire [15:0] i_unit_cycles,
  // Clear sources and the other-fault input
  input wire i_status_clr,
  input wire i_clear_faults,
  input wire i_op_on,
  input wire i_ctrl_pin,
  input wire i_other_fault,
  // Outputs
  output reg o_out_en,
  output reg o_fault_status,
  output reg [15:0] o_ovlim
);
  localparam ST_RUN = 3'd0;
  localparam ST_DELAY = 3'd1;
  localparam ST_OFFWAIT = 3'd2;
  localparam ST_TRY = 3'd3;
  localparam ST_LATCH = 3'd4;
  reg [7:0] action_r;
  reg [15:0] thresh_r;
  reg [2:0] st_r;
  reg [2:0] tries_r;
  reg p1_r, p2_r, p3_r, pin_r;
  reg on_q_r;
  reg tmr_start_r;
  wire tmr_done;
  wire fault;
  wire on_now;
  wire cycle_off;
  wire [1:0] resp;
  wire [2:0] retry;
  assign resp = action_r[`CFR_RESP_HI:`CFR_RESP_LO];
  assign retry = action_r[`CFR_RETRY_HI:`CFR_RETRY_LO];
  assign fault = (i_temp < $signed(thresh_r));
  assign on_now = pin_r & i_op_on;
  assign cycle_off = on_q_r & ~on_now;
  // ==========================================
  // Pin synchroniser: change accepted when stages two and three agree
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      p1_r <= 1'b0;
      p2_r <= 1'b0;
      p3_r <= 1'b0;
      pin_r <= 1'b0;
      on_q_r <= 1'b0;
    end
    else
    begin
      p1_r <= i_ctrl_pin;
      p2_r <= p1_r;
      p3_r <= p2_r;
      if (p2_r == p3_r)
        pin_r <= p3_r;
      on_q_r <= on_now;
    end
  end
  // ==========================================
  // Delay timer shared by run-on and retry spacing
  cfr_unit_tick u_tick
  (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(tmr_start_r),
    .i_code(action_r[`CFR_DLY_HI:`CFR_DLY_LO]),
    .i_unit_cycles(i_unit_cycles),
    .o_done(tmr_done)
  );
  // ==========================================
  // Command registers
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      action_r <= `CFR_ACTION_RST;
      thresh_r <= `CFR_THRESH_RST;
      o_ovlim <= `CFR_OVLIM_RST;
      o_cmd_rdata <= 16'h0000;
      o_cmd_ack <= 1'b0;
    end
    else
    begin
      o_cmd_ack <= i_cmd_wr | i_cmd_rd;
      if (i_cmd_wr)
      begin
        case (i_cmd_code)
          `CFR_CMD_ACTION: action_r <= i_cmd_wdata[7:0];
          `CFR_CMD_OVLIM: o_ovlim <= i_cmd_wdata;
          `CFR_CMD_THRESH: thresh_r <= i_cmd_wdata;
          default: ;
        endcase
      end
      if (i_cmd_rd)
      begin
        case (i_cmd_code)
          `CFR_CMD_ACTION: o_cmd_rdata <= {8'h00, action_r};
          `CFR_CMD_OVLIM: o_cmd_rdata <= o_ovlim;
          `CFR_CMD_THRESH: o_cmd_rdata <= thresh_r;
          default: o_cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end
  // ==========================================
  // Fault response state machine
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= ST_RUN;
      tries_r <= 3'd0;
      tmr_start_r <= 1'b0;
      o_out_en <= 1'b1;
      o_fault_status <= 1'b0;
    end
    else
    begin
      tmr_start_r <= 1'b0;
      // Status flag: a new fault wins over a clear in the same cycle
      if (fault && resp != `CFR_RESP_IGNORE)
        o_fault_status <= 1'b1;
      else if (i_status_clr || i_clear_faults || cycle_off)
        o_fault_status <= 1'b0;
      if ((i_status_clr || i_clear_faults || cycle_off) && st_r != ST_RUN)
      begin
        st_r <= ST_RUN;
        o_out_en <= 1'b1;
      end
      else
      begin
        case (st_r)
          ST_RUN:
          begin
            o_out_en <= 1'b1;
            tries_r <= 3'd0;
            if (fault)
            begin
              case (resp)
                `CFR_RESP_DELAY:
                begin
                  st_r <= ST_DELAY;
                  tmr_start_r <= 1'b1;
                end
                `CFR_RESP_RETRY:
                begin
                  o_out_en <= 1'b0;
                  st_r <= (retry == `CFR_RETRY_NONE) ? ST_LATCH : ST_OFFWAIT;
                  tmr_start_r <= 1'b1;
                end
                `CFR_RESP_LATCH:
                begin
                  o_out_en <= 1'b0;
                  st_r <= ST_LATCH;
                end
                default: st_r <= ST_RUN;
              endcase
            end
          end
          ST_DELAY:
          begin
            if (tmr_done)
            begin
              if (!fault)
                st_r <= ST_RUN;
              else
              begin
                o_out_en <= 1'b0;
                st_r <= (retry == `CFR_RETRY_NONE) ? ST_LATCH : ST_OFFWAIT;
                tmr_start_r <= 1'b1;
              end
            end
          end
          ST_OFFWAIT:
          begin
            if (i_other_fault || !on_now)
              st_r <= ST_LATCH;
            else if (tmr_done)
            begin
              o_out_en <= 1'b1;
              tries_r <= tries_r + 3'd1;
              tmr_start_r <= 1'b1;
              st_r <= ST_TRY;
            end
          end
          ST_TRY:
          begin
            if (!fault)
              st_r <= ST_RUN;
            else if (tmr_done)
            begin
              o_out_en <= 1'b0;
              if (retry != `CFR_RETRY_ALWAYS && tries_r >= retry)
                st_r <= ST_LATCH;
              else
              begin
                tmr_start_r <= 1'b1;
                st_r <= ST_OFFWAIT;
              end
            end
          end
          ST_LATCH: o_out_en <= 1'b0;
          default: st_r <= ST_RUN;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/cfr_map.vh ====
// Command codes, field positions, field encodings and reset values for the cold-fault response block
`ifndef CFR_MAP_VH
`define CFR_MAP_VH
`define CFR_CMD_THRESH 8'h53
`define CFR_CMD_ACTION 8'h54
`define CFR_CMD_OVLIM 8'h55
`define CFR_RESP_HI 7
`define CFR_RESP_LO 6
`define CFR_RETRY_HI 5
`define CFR_RETRY_LO 3
`define CFR_DLY_HI 2
`define CFR_DLY_LO 0
`define CFR_RESP_IGNORE 2'b00
`define CFR_RESP_DELAY 2'b01
`define CFR_RESP_RETRY 2'b10
`define CFR_RESP_LATCH 2'b11
`define CFR_RETRY_NONE 3'b000
`define CFR_RETRY_ALWAYS 3'b111
`define CFR_ACTION_RST 8'h00
`define CFR_THRESH_RST 16'h0000
`define CFR_OVLIM_RST 16'hFFFF
`endif

// ==== verilog/cfr_unit_tick.v ====
// Delay-unit tick generator and power-of-two delay counter
`timescale 1ns/1ps
`default_nettype none
module cfr_unit_tick
(
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Control
  input wire i_start,
  input wire [2:0] i_code,
  input wire [15:0] i_unit_cycles,
  // Status
  output reg o_done
);
  reg [15:0] pre_r;
  reg [7:0] units_r;
  reg run_r;
  wire unit_tick;
  assign unit_tick = run_r && (pre_r >= i_unit_cycles);
  // ==========================================
  // Unit counter: counts 2**code units of the configured length
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pre_r <= 16'h0000;
      units_r <= 8'h00;
      run_r <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        pre_r <= 16'h0001;
        units_r <= 8'h01 << i_code;
        run_r <= 1'b1;
      end
      else if (unit_tick)
      begin
        pre_r <= 16'h0001;
        units_r <= units_r - 8'h01;
        if (units_r == 8'h01)
        begin
          run_r <= 1'b0;
          o_done <= 1'b1;
        end
      end
      else if (run_r)
      begin
        pre_r <= pre_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire
